// *** src/cpr_param_regs.sv ***
// port parameter register bank with avalon-mm slave and interrupt
//
// Design decision made here: the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module cpr_param_regs #(
    parameter logic [12:0] BUF_SIZE = 13'h0000
) (
    input  wire logic                   sys_clk,
    input  wire logic                   rst_n,
    input  wire logic [8:0]             avs_address,
    input  wire logic                   avs_read,
    input  wire logic                   avs_write,
    input  wire logic [31:0]            avs_writedata,
    input  wire logic [3:0]             avs_byteenable,
    output logic      [31:0]            avs_readdata,
    output logic                        avs_waitrequest,
    input  wire cpr_pkg::cpr_port_state_t port_state,
    input  wire logic                   init_load,
    input  wire cpr_pkg::cpr_init_t     init_param,
    input  wire cpr_pkg::cpr_err_t      err_event,
    output logic      [31:0]            queue_base,
    output cpr_pkg::cpr_link_t          link_ctrl,
    output logic      [7:0]             node_limit,
    output logic                        param_valid,
    output logic                        irq
);
    localparam int W = cpr_pkg::CPR_STAT_W;

    // ****************************************************
    // bus handshake: one wait cycle, then the answer
    // ****************************************************
    logic        req;
    logic        acc_wr;
    logic [31:0] be_mask;
    logic [31:0] rd_mux;
    logic        next_waitrequest;
    logic [31:0] next_readdata;

    assign req    = avs_read | avs_write;
    assign acc_wr = avs_write & ~avs_waitrequest;
    assign be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                      {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

    // ****************************************************
    // register state
    // ****************************************************
    logic [W-1:0] flags;
    logic [W-1:0] mask;
    logic [W-1:0] ev_set;
    logic [W-1:0] ev_clr;
    logic [31:0]  fail_addr;
    logic [31:0]  err_detail;
    logic [2:0]   node_code;
    logic [2:0]   qss;
    logic         loaded;
    logic         was_uninit;
    logic         qbase_open;
    logic [2:0]   clean_node;
    logic [2:0]   clean_qss;
    logic         clamped;

    logic [31:0]  next_queue_base;
    logic [W-1:0] next_mask;
    logic [31:0]  next_fail_addr;
    logic [31:0]  next_err_detail;
    logic [2:0]   next_node_code;
    logic [2:0]   next_qss;
    logic         next_loaded;
    logic         next_param_valid;
    logic         next_irq;
    cpr_pkg::cpr_link_t next_link_ctrl;
    logic [7:0]   next_node_limit;

    function automatic logic [5:0] quiet_count(input logic [2:0] sel);
        case (sel)
            3'h0:    quiet_count = cpr_pkg::CPR_QS_0;
            3'h1:    quiet_count = cpr_pkg::CPR_QS_1;
            3'h2:    quiet_count = cpr_pkg::CPR_QS_2;
            3'h3:    quiet_count = cpr_pkg::CPR_QS_3;
            3'h4:    quiet_count = cpr_pkg::CPR_QS_4;
            3'h5:    quiet_count = cpr_pkg::CPR_QS_5;
            3'h6:    quiet_count = cpr_pkg::CPR_QS_6;
            default: quiet_count = cpr_pkg::CPR_QS_0;
        endcase
    endfunction

    // ****************************************************
    // read mux
    // ****************************************************
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (avs_address)
            cpr_pkg::CPR_OFS_QBASE:     rd_mux = queue_base;
            cpr_pkg::CPR_OFS_FAIL_ADDR: rd_mux = fail_addr;
            cpr_pkg::CPR_OFS_PARAMS: begin
                // reserved 15:13 and low byte stay zero
                if (param_valid) begin
                    rd_mux[31:29] = node_code;
                    rd_mux[28:16] = BUF_SIZE;
                    rd_mux[12]    = link_ctrl.arb_bypass;
                    rd_mux[11]    = link_ctrl.ext_header;
                    rd_mux[10:8]  = qss;
                end
            end
            cpr_pkg::CPR_OFS_ERR_DET:   rd_mux = err_detail;
            cpr_pkg::CPR_OFS_IRQ_STAT:  rd_mux[W-1:0] = flags;
            cpr_pkg::CPR_OFS_IRQ_MASK:  rd_mux[W-1:0] = mask;
            default:                    rd_mux = 32'h0000_0000;
        endcase
    end

    always_comb begin
        next_waitrequest = 1'b1;
        next_readdata    = avs_readdata;
        if (req && avs_waitrequest) begin
            next_waitrequest = 1'b0;
            next_readdata    = avs_read ? rd_mux : 32'h0000_0000;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0000_0000;
        end else begin
            avs_waitrequest <= next_waitrequest;
            avs_readdata    <= next_readdata;
        end
    end

    // ****************************************************
    // register updates
    // ****************************************************
    // a write while the port runs would move its queues underneath it
    assign qbase_open = (port_state == cpr_pkg::CPR_DISABLED) ||
                        (port_state == cpr_pkg::CPR_DIS_MAINT);

    always_comb begin
        // reserved codes fall back to the smallest legal setting
        clean_node = init_param.node_count_code;
        clean_qss  = init_param.quiet_slot_select;
        clamped    = 1'b0;
        if (init_param.node_count_code[2]) begin
            clean_node = cpr_pkg::CPR_NODE_SAFE;
            clamped    = 1'b1;
        end
        if (init_param.quiet_slot_select == cpr_pkg::CPR_QSS_ILLEGAL) begin
            clean_qss = cpr_pkg::CPR_QSS_SAFE;
            clamped   = 1'b1;
        end
    end

    always_comb begin
        next_queue_base = queue_base;
        next_mask       = mask;
        next_fail_addr  = fail_addr;
        next_err_detail = err_detail;
        next_node_code  = node_code;
        next_qss        = qss;
        next_loaded     = loaded;
        next_link_ctrl  = link_ctrl;
        ev_clr          = '0;
        ev_set          = '0;
        if (acc_wr) begin
            case (avs_address)
                cpr_pkg::CPR_OFS_QBASE: begin
                    if (qbase_open) begin
                        next_queue_base = ((queue_base & ~be_mask) |
                            (avs_writedata & be_mask)) &
                            cpr_pkg::CPR_QBASE_FIELD;
                    end
                end
                cpr_pkg::CPR_OFS_IRQ_STAT:
                    ev_clr = avs_writedata[W-1:0] & be_mask[W-1:0];
                cpr_pkg::CPR_OFS_IRQ_MASK:
                    next_mask = (mask & ~be_mask[W-1:0]) |
                                (avs_writedata[W-1:0] & be_mask[W-1:0]);
                // the read-only registers drop writes, so a stray store
                // cannot corrupt the parameters or error capture
                default: next_mask = mask;
            endcase
        end
        if (err_event.valid) begin
            next_fail_addr = err_event.addr;
            case (err_event.kind)
                cpr_pkg::CPR_ERR_DSE: begin
                    next_err_detail           = err_event.detail;
                    ev_set[cpr_pkg::CPR_EV_DSE] = 1'b1;
                end
                cpr_pkg::CPR_ERR_MSE:
                    ev_set[cpr_pkg::CPR_EV_MSE] = 1'b1;
                default:
                    ev_set[cpr_pkg::CPR_EV_BUF_MSE] = 1'b1;
            endcase
        end
        if (port_state == cpr_pkg::CPR_UNINIT && !was_uninit) begin
            next_loaded = 1'b0;
        end
        if (init_load) begin
            next_loaded                    = 1'b1;
            next_node_code                 = clean_node;
            next_qss                       = clean_qss;
            next_link_ctrl.arb_bypass      = init_param.arb_bypass;
            next_link_ctrl.ext_header      = init_param.ext_header;
            next_link_ctrl.quiet_slots     = quiet_count(clean_qss);
            ev_set[cpr_pkg::CPR_EV_LOADED]  = 1'b1;
            ev_set[cpr_pkg::CPR_EV_CLAMPED] = clamped;
        end
        next_node_limit  = 8'(cpr_pkg::CPR_NODE_BASE << next_node_code[1:0]);
        next_param_valid = next_loaded &&
                           (port_state != cpr_pkg::CPR_UNINIT);
        // one cycle behind the flag, interrupt is a registered output
        next_irq         = |(flags & mask);
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            queue_base  <= cpr_pkg::CPR_QBASE_RESET;
            mask        <= cpr_pkg::CPR_MASK_RESET;
            fail_addr   <= 32'h0000_0000;
            err_detail  <= 32'h0000_0000;
            node_code   <= 3'h0;
            qss         <= 3'h0;
            loaded      <= 1'b0;
            was_uninit  <= 1'b0;
            link_ctrl   <= '{arb_bypass: 1'b0, ext_header: 1'b0,
                             quiet_slots: cpr_pkg::CPR_QS_0};
            node_limit  <= cpr_pkg::CPR_NODE_BASE;
            param_valid <= 1'b0;
            irq         <= 1'b0;
        end else begin
            queue_base  <= next_queue_base;
            mask        <= next_mask;
            fail_addr   <= next_fail_addr;
            err_detail  <= next_err_detail;
            node_code   <= next_node_code;
            qss         <= next_qss;
            loaded      <= next_loaded;
            was_uninit  <= (port_state == cpr_pkg::CPR_UNINIT);
            link_ctrl   <= next_link_ctrl;
            node_limit  <= next_node_limit;
            param_valid <= next_param_valid;
            irq         <= next_irq;
        end
    end

    cpr_w1c_flags #(
        .W     (W)
    ) u_flags (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .set     (ev_set),
        .clr     (ev_clr),
        .flags   (flags)
    );

    // ****************************************************
    // checks
    // ****************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sequence s_wait_one;
        req && avs_waitrequest && !$past(req && avs_waitrequest);
    endsequence
    sequence s_answer;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence
    sequence s_qbase_full_wr;
        acc_wr && avs_address == cpr_pkg::CPR_OFS_QBASE &&
            avs_byteenable == 4'hf && qbase_open;
    endsequence

    a_bus_answer: assert property (s_wait_one |=> s_answer)
        else $error("bus answer not one cycle after request");
    a_qbase_mbz: assert property ((queue_base & ~cpr_pkg::CPR_QBASE_FIELD)
        == 32'h0000_0000)
        else $error("queue base must-be-zero bit set");
    a_qbase_write: assert property (s_qbase_full_wr |=> queue_base ==
        ($past(avs_writedata) & cpr_pkg::CPR_QBASE_FIELD))
        else $error("queue base write not stored");
    a_qbase_locked: assert property (acc_wr && !qbase_open &&
        avs_address == cpr_pkg::CPR_OFS_QBASE |=> $stable(queue_base))
        else $error("queue base changed while port enabled");
    a_fail_capture: assert property (err_event.valid |=>
        fail_addr == $past(err_event.addr))
        else $error("failing address not captured");
    a_fail_ro: assert property (acc_wr && !err_event.valid &&
        avs_address == cpr_pkg::CPR_OFS_FAIL_ADDR |=> $stable(fail_addr))
        else $error("failing address written by software");
    a_param_uninit: assert property (port_state == cpr_pkg::CPR_UNINIT
        |=> !param_valid)
        else $error("parameters valid while uninitialized");
    a_node_limit: assert property (param_valid |-> !node_code[2] &&
        node_limit == 8'(cpr_pkg::CPR_NODE_BASE << node_code[1:0]))
        else $error("node limit disagrees with node count code");
    a_param_read: assert property (!avs_waitrequest && avs_read &&
        avs_address == cpr_pkg::CPR_OFS_PARAMS |-> avs_readdata[15:13] == 3'h0
        && (!param_valid || avs_readdata[28:16] == BUF_SIZE))
        else $error("parameter read shows bad reserved or buffer field");
    a_link_load: assert property (init_load |=> link_ctrl.arb_bypass ==
        $past(init_param.arb_bypass) && link_ctrl.ext_header ==
        $past(init_param.ext_header))
        else $error("link controls not loaded");
    a_quiet_count: assert property (link_ctrl.quiet_slots >= 6'h07 &&
        link_ctrl.quiet_slots <= 6'h20 && qss != cpr_pkg::CPR_QSS_ILLEGAL)
        else $error("quiet slot count out of range");
    a_detail_hold: assert property (err_event.valid &&
        err_event.kind != cpr_pkg::CPR_ERR_DSE |=> $stable(err_detail))
        else $error("error detail changed without structure error");
endmodule // cpr_param_regs
`default_nettype wire

// *** src/cpr_pkg.sv ***
// constants and carrier types of the port parameter register bank
// Function
// - queue base keeps bits 28:9, others zero
// - failing address captured on structure/memory errors
// - failing address read only, valid after errors
// - microcode loads parameters; invalid while uninitialized
// - bits 31:29 report cluster node count
// - bits 28:16 report preset buffer size
// - parameter bits 15:13 read as zero
// - bit 12 bypasses arbitration, one quiet slot (quiet_slots still set by bits 10:8)
// - bit 11 allows extended header sync run
// - bits 10:8 force quiet slot count
// - error detail identifies structure error type
package cpr_pkg;

    // ****************************************************
    // register map (byte addresses)
    // ****************************************************
    localparam int          CPR_ADDR_W        = 9;
    localparam logic [8:0]  CPR_OFS_QBASE     = 9'h0f0;
    localparam logic [8:0]  CPR_OFS_FAIL_ADDR = 9'h0f4;
    localparam logic [8:0]  CPR_OFS_PARAMS    = 9'h0f8;
    localparam logic [8:0]  CPR_OFS_ERR_DET   = 9'h0fc;
    localparam logic [8:0]  CPR_OFS_IRQ_STAT  = 9'h100;
    localparam logic [8:0]  CPR_OFS_IRQ_MASK  = 9'h104;

    // ****************************************************
    // field layouts and reset values
    // ****************************************************
    localparam logic [31:0] CPR_QBASE_FIELD   = 32'h1fff_fe00;
    localparam logic [31:0] CPR_QBASE_RESET   = 32'h0000_0000;
    localparam int          CPR_NODE_LSB      = 29;
    localparam int          CPR_BUF_LSB       = 16;
    localparam int          CPR_ARB_BIT       = 12;
    localparam int          CPR_HDR_BIT       = 11;
    localparam int          CPR_QSS_LSB       = 8;
    localparam logic [2:0]  CPR_NODE_SAFE     = 3'h0;
    localparam logic [2:0]  CPR_QSS_ILLEGAL   = 3'h7;
    localparam logic [2:0]  CPR_QSS_SAFE      = 3'h0;
    localparam logic [7:0]  CPR_NODE_BASE     = 8'h10;

    // interrupt status layout, one sticky bit per event
    localparam int          CPR_STAT_W        = 5;
    localparam int          CPR_EV_DSE        = 0;
    localparam int          CPR_EV_MSE        = 1;
    localparam int          CPR_EV_BUF_MSE    = 2;
    localparam int          CPR_EV_LOADED     = 3;
    localparam int          CPR_EV_CLAMPED    = 4;
    localparam logic [4:0]  CPR_MASK_RESET    = 5'h00;

    // quiet slot counts per select code
    localparam logic [5:0]  CPR_QS_0          = 6'h07;
    localparam logic [5:0]  CPR_QS_1          = 6'h0a;
    localparam logic [5:0]  CPR_QS_2          = 6'h0e;
    localparam logic [5:0]  CPR_QS_3          = 6'h10;
    localparam logic [5:0]  CPR_QS_4          = 6'h15;
    localparam logic [5:0]  CPR_QS_5          = 6'h19;
    localparam logic [5:0]  CPR_QS_6          = 6'h20;

    // ****************************************************
    // types
    // ****************************************************
    typedef enum logic [1:0] {
        CPR_UNINIT    = 2'h0,
        CPR_DISABLED  = 2'h1,
        CPR_DIS_MAINT = 2'h3,
        CPR_ENABLED   = 2'h2
    } cpr_port_state_t;

    typedef enum logic [1:0] {
        CPR_ERR_DSE     = 2'h0,
        CPR_ERR_MSE     = 2'h1,
        CPR_ERR_BUF_MSE = 2'h3
    } cpr_err_kind_t;

    typedef struct packed {
        logic [2:0] node_count_code;
        logic       arb_bypass;
        logic       ext_header;
        logic [2:0] quiet_slot_select;
    } cpr_init_t;

    typedef struct packed {
        logic          valid;
        cpr_err_kind_t kind;
        logic [31:0]   addr;
        logic [31:0]   detail;
    } cpr_err_t;

    typedef struct packed {
        logic       arb_bypass;
        logic       ext_header;
        logic [5:0] quiet_slots;
    } cpr_link_t;

endpackage

// *** src/cpr_w1c_flags.sv ***
// sticky event flags, write one to clear, set beats clear
`timescale 1ns/100ps
`default_nettype none
module cpr_w1c_flags #(
    parameter int W = 5
) (
    input  wire logic         sys_clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] set,
    input  wire logic [W-1:0] clr,
    output logic      [W-1:0] flags
);
    logic [W-1:0] next_flags;

    always_comb begin
        next_flags = (flags & ~clr) | set;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            flags <= '0;
        end else begin
            flags <= next_flags;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    a_set_wins: assert property (|set |=> (flags & $past(set)) == $past(set))
        else $error("event flag lost while being cleared");
endmodule // cpr_w1c_flags
`default_nettype wire

// *** tb/cpr_param_regs_test.sv ***
// self-checking bench of the port parameter register bank
`timescale 1ns/100ps
`default_nettype none
module cpr_param_regs_test;
    localparam logic [12:0] BUF = 13'h1a5;
    localparam logic [31:0] QMASK = 32'h1fff_fe00;
    logic                      sys_clk;
    logic                      rst_n;
    logic [8:0]                avs_address;
    logic                      avs_read;
    logic                      avs_write;
    logic [31:0]               avs_writedata;
    logic [3:0]                avs_byteenable;
    logic [31:0]               avs_readdata;
    logic                      avs_waitrequest;
    cpr_pkg::cpr_port_state_t  port_state;
    logic                      init_load;
    cpr_pkg::cpr_init_t        init_param;
    cpr_pkg::cpr_err_t         err_event;
    logic [31:0]               queue_base;
    cpr_pkg::cpr_link_t        link_ctrl;
    logic [7:0]                node_limit;
    logic                      param_valid;
    logic                      irq;
    int                        bad_count;
    int                        samples_checked;
    int                        seed;
    logic [31:0]               v;
    logic [31:0]               qb_exp;
    logic [31:0]               det_exp;
    logic [31:0]               par_exp;
    logic [5:0]                qs_tab [0:6] = '{6'h07, 6'h0a, 6'h0e, 6'h10,
                                                6'h15, 6'h19, 6'h20};

    cpr_param_regs #(.BUF_SIZE(BUF)) dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .port_state(port_state), .init_load(init_load),
        .init_param(init_param), .err_event(err_event),
        .queue_base(queue_base), .link_ctrl(link_ctrl),
        .node_limit(node_limit), .param_valid(param_valid), .irq(irq));

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // ****************************************************
    // shared tasks
    // ****************************************************
    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    // entered just after a rising edge; leaves one edge after completion
    task automatic bus(input logic wr, input logic [8:0] a,
                       input logic [31:0] d, input logic [3:0] be,
                       output logic [31:0] q);
        int n;
        avs_address    <= a;
        avs_write      <= wr;
        avs_read       <= ~wr;
        avs_writedata  <= d;
        avs_byteenable <= be;
        for (n = 0; n < 20; n++) begin
            @(posedge sys_clk);
            if (avs_waitrequest === 1'b0) break;
        end
        q = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        if (n == 20) begin
            bad_count++;
            report_and_stop();
        end
        @(posedge sys_clk);
    endtask

    function automatic logic [31:0] lanes(input logic [3:0] be);
        return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction

    // illegal codes come back clamped to zero
    task automatic load(input logic [7:0] p);
        logic [2:0] ce;
        logic [2:0] qe;
        ce = p[7] ? 3'h0 : p[7:5];
        qe = (p[2:0] == 3'h7) ? 3'h0 : p[2:0];
        init_load  <= 1'b1;
        init_param <= p;
        @(posedge sys_clk);
        init_load <= 1'b0;
        @(posedge sys_clk);
        check({24'h0, link_ctrl}, {24'h0, p[4], p[3], qs_tab[qe]});
        check({24'h0, node_limit}, {24'h0, 8'h10 << ce});
        check({31'h0, param_valid}, 32'h1);
        par_exp = {ce, BUF, 3'h0, p[4], p[3], qe, 8'h00};
        bus(1'b0, 9'h0f8, 32'h0, 4'hf, v);
        check(v, par_exp);
    endtask

    task automatic err(input cpr_pkg::cpr_err_kind_t k, input int bit_no);
        logic [31:0] a;
        logic [31:0] d;
        a = $random(seed);
        d = $random(seed);
        if (k == cpr_pkg::CPR_ERR_DSE) det_exp = d;
        err_event <= {1'b1, k, a, d};
        @(posedge sys_clk);
        err_event.valid <= 1'b0;
        @(posedge sys_clk);
        bus(1'b1, 9'h0f4, ~a, 4'hf, v);
        bus(1'b0, 9'h0f4, 32'h0, 4'hf, v);
        check(v, a);
        bus(1'b0, 9'h0fc, 32'h0, 4'hf, v);
        check(v, det_exp);
        bus(1'b0, 9'h100, 32'h0, 4'hf, v);
        check(v, 32'h1 << bit_no);
    endtask

    // ****************************************************
    // main sequence
    // ****************************************************
    initial begin
        seed = 71;
        bad_count = 0;
        samples_checked = 0;
        rst_n = 1'b0;
        avs_address = 9'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'h0;
        port_state = cpr_pkg::CPR_UNINIT;
        init_load = 1'b0;
        init_param = 8'h00;
        err_event = '0;
        det_exp = 32'h0;
        qb_exp = 32'h0;
        repeat (5) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        check({8'h0, link_ctrl, node_limit, 7'h0, irq}, 32'h0007_1000);
        check({31'h0, param_valid}, 32'h0);
        bus(1'b0, 9'h0f8, 32'h0, 4'hf, v);
        check(v, 32'h0);
        $display("reset test done");

        port_state <= cpr_pkg::CPR_DISABLED;
        for (int i = 0; i < 12; i++) begin
            logic [31:0] d;
            logic [3:0]  be;
            d  = $random(seed);
            be = (i < 4) ? 4'hf : 4'($random(seed));
            if (i == 8) port_state <= cpr_pkg::CPR_ENABLED;
            if (i == 9) port_state <= cpr_pkg::CPR_UNINIT;
            if (i == 10) port_state <= cpr_pkg::CPR_DIS_MAINT;
            bus(1'b1, 9'h0f0, d, be, v);
            if (i < 8 || i > 9) begin
                qb_exp = ((qb_exp & ~lanes(be)) | (d & lanes(be))) & QMASK;
            end
            check(queue_base, qb_exp);
            bus(1'b0, 9'h0f0, 32'h0, 4'hf, v);
            check(v, qb_exp);
        end
        $display("queue base test done");

        for (int i = 0; i < 16; i++) begin
            logic [2:0] c;
            c = 3'(i);
            load((i < 8) ? {c, c[0], c[1], c} : 8'($random(seed)));
            bus(1'b1, 9'h0f8, 32'hffff_ffff, 4'hf, v);
            bus(1'b0, 9'h0f8, 32'h0, 4'hf, v);
            check(v, par_exp);
        end
        bus(1'b0, 9'h100, 32'h0, 4'hf, v);
        check(v, 32'h18);
        bus(1'b1, 9'h100, 32'h1f, 4'hf, v);
        bus(1'b0, 9'h100, 32'h0, 4'hf, v);
        check(v, 32'h0);
        $display("parameter test done");

        bus(1'b1, 9'h104, 32'h1f, 4'hf, v);
        bus(1'b0, 9'h104, 32'h0, 4'hf, v);
        check(v, 32'h1f);
        err(cpr_pkg::CPR_ERR_DSE, 0);
        check({31'h0, irq}, 32'h1);
        bus(1'b1, 9'h100, 32'h1, 4'h1, v);
        err(cpr_pkg::CPR_ERR_BUF_MSE, 2);
        bus(1'b1, 9'h100, 32'h4, 4'h1, v);
        bus(1'b1, 9'h104, 32'h0, 4'hf, v);
        err(cpr_pkg::CPR_ERR_MSE, 1);
        check({31'h0, irq}, 32'h0);
        bus(1'b1, 9'h104, 32'h2, 4'hf, v);
        repeat (2) @(posedge sys_clk);
        check({31'h0, irq}, 32'h1);
        bus(1'b1, 9'h100, 32'h2, 4'h1, v);
        repeat (2) @(posedge sys_clk);
        check({31'h0, irq}, 32'h0);
        $display("error test done");

        port_state <= cpr_pkg::CPR_UNINIT;
        repeat (3) @(posedge sys_clk);
        check({31'h0, param_valid}, 32'h0);
        bus(1'b0, 9'h0f8, 32'h0, 4'hf, v);
        check(v, 32'h0);
        bus(1'b0, 9'h0c0, 32'h0, 4'hf, v);
        check(v, 32'h0);
        $display("uninit and unmapped test done");
        report_and_stop();
    end
endmodule // cpr_param_regs_test
`default_nettype wire
